//--- include/subset_exec_pkg.sv
// Package for the instruction subset executor: opcodes, field layout,
// reset values and the shared instruction record.
// Assumes 14-bit instruction words and a 15-bit program counter.
package subset_exec_pkg;

    // Word and field widths
    localparam int INSN_W = 14;
    localparam int PC_W = 15;
    localparam int FADDR_W = 7;

    // Field positions inside the instruction word
    localparam int F_LSB = 0;
    localparam int D_POS = 7;
    localparam int B_LSB = 7;
    localparam int K9_LSB = 0;
    localparam int K11_LSB = 0;

    // Opcode patterns (upper bits, or the whole word) for the decoded subset
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_LOW = 4'h6;
    localparam logic [3:0] OPC_SKIP_HIGH = 4'h7;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [4:0] OPC_REL_JUMP = 5'h19;
    localparam logic [5:0] OPC_INVERT = 6'h09;
    localparam logic [5:0] OPC_DECREMENT = 6'h03;
    localparam logic [5:0] OPC_CLEAR_GRP = 6'h01;
    localparam logic [13:0] OPC_JUMP_ACC = 14'h000B;
    localparam logic [13:0] OPC_CALL_ACC = 14'h000A;
    localparam logic [13:0] OPC_WDT_KICK = 14'h0064;
    localparam logic [13:0] OPC_IDLE = 14'h0000;

    // Values after reset
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] WDT_CLEAR = 8'h00;

    // Kinds of operation
    typedef enum {
        OP_IDLE, OP_BCLR, OP_BSET, OP_SKIP_LOW, OP_SKIP_HIGH, OP_REL,
        OP_JACC, OP_CALL, OP_CALL_ACC, OP_WDT, OP_INV, OP_FCLR,
        OP_ACLR, OP_DEC
    } op_kind_t;

    // Decoded instruction record
    typedef struct packed {
        logic [FADDR_W-1:0] faddr;
        logic [2:0] bit_sel;
        logic dest_file;
        logic [8:0] k9;
        logic [10:0] k11;
    } insn_fields_t;

    // File register write request
    typedef struct packed {
        logic en;
        logic [FADDR_W-1:0] addr;
        logic [7:0] data;
    } file_write_t;

endpackage

//--- rtl/subset_exec.sv
// Decode and execute of an instruction subset of an 8-bit core:
// bit ops, skips, branches, calls, watchdog kick, clear, invert, decrement.
// Assumes one instruction word per clock, file reads combinational.
// The file array and the return stack sit outside; this block only
// raises a write or a push, one cycle after the word that asks.
// No watchdog tick source is here, so its count only returns to zero.
//
// Behaviour
// - bit clear zeroes bit, flags untouched
// - bit set forces bit one, flags untouched
// - skip low discards next when bit zero
// - skip high discards next when bit one
// - relative jump to PC+1+signed k, two cycles
// - jump by accumulator to PC+1+W, two cycles
// - call pushes PC+1, loads eleven-bit k
// - call takes PC<12:11> from latch bits 4:3
// - accumulator call pushes PC+1, two cycles
// - accumulator call: PC<7:0>=W, PC<14:8>=latch
// - watchdog kick clears counter, prescaler, sets flags
// - invert file to W or f, zero flag
// - file zeroing writes 00h, sets zero flag
// - accumulator zeroing writes 00h, sets zero flag
// - decrement file to W or f, zero flag
`timescale 1ns/1ps

module subset_exec (
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // Instruction fetch
    input wire logic [subset_exec_pkg::INSN_W-1:0] insn_in,
    output logic [subset_exec_pkg::PC_W-1:0] pc_out,
    // File register port
    output logic [subset_exec_pkg::FADDR_W-1:0] file_addr_out,
    input wire logic [7:0] file_rdata_in,
    output subset_exec_pkg::file_write_t file_write_out,
    // Upper program counter latch
    input wire logic [6:0] upper_pc_latch_in,
    // Return stack push
    output logic push_out,
    output logic [subset_exec_pkg::PC_W-1:0] return_slot_out,
    // Core state
    output logic [7:0] acc_out,
    output logic null_result_flag_out,
    output logic expiry_flag_out,
    output logic sleep_flag_out,
    output logic watchdog_clear_out,
    output logic [7:0] watchdog_counter_out,
    output logic [7:0] watchdog_prescaler_out,
    output logic bubble_out
);
    import subset_exec_pkg::*;

    // Architectural state
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic zero_flag;
    logic expiry_flag;
    logic sleep_flag;
    logic [7:0] wdt_count;
    logic [7:0] wdt_prescale;
    logic bubble;

    // Decode and datapath nets
    op_kind_t op;
    insn_fields_t fld;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] next_pc;
    // Computed byte and its qualifier
    logic [7:0] result;
    logic result_valid;
    logic test_bit;
    logic [7:0] bit_mask;
    logic skip_next;
    // Write request before its register
    file_write_t next_write;

    // Field extraction from the current word; every field is cut from
    // every word and the decode decides which of them apply
    always_comb begin
        fld.faddr = insn_in[F_LSB +: FADDR_W];
        fld.bit_sel = insn_in[B_LSB +: 3];
        fld.dest_file = insn_in[D_POS];
        fld.k9 = insn_in[K9_LSB +: 9];
        fld.k11 = insn_in[K11_LSB +: 11];
    end

    // Opcode decode; a discarded word always decodes as idle
    // Words outside the subset also fall through to idle, so an
    // unknown opcode only advances the counter
    always_comb begin
        op = OP_IDLE;
        if (bubble) begin
            op = OP_IDLE;
        end else if (insn_in == OPC_JUMP_ACC) begin
            op = OP_JACC;
        end else if (insn_in == OPC_CALL_ACC) begin
            op = OP_CALL_ACC;
        end else if (insn_in == OPC_WDT_KICK) begin
            op = OP_WDT;
        end else if (insn_in[13:10] == OPC_BIT_CLEAR) begin
            op = OP_BCLR;
        end else if (insn_in[13:10] == OPC_BIT_SET) begin
            op = OP_BSET;
        end else if (insn_in[13:10] == OPC_SKIP_LOW) begin
            op = OP_SKIP_LOW;
        end else if (insn_in[13:10] == OPC_SKIP_HIGH) begin
            op = OP_SKIP_HIGH;
        end else if (insn_in[13:11] == OPC_CALL) begin
            op = OP_CALL;
        end else if (insn_in[13:9] == OPC_REL_JUMP) begin
            op = OP_REL;
        end else if (insn_in[13:8] == OPC_INVERT) begin
            op = OP_INV;
        end else if (insn_in[13:8] == OPC_DECREMENT) begin
            op = OP_DEC;
        end else if (insn_in[13:8] == OPC_CLEAR_GRP) begin
            op = fld.dest_file ? OP_FCLR : OP_ACLR;
        end
    end

    // Fall-through address, tested bit and single-bit mask
    assign pc_inc = pc + 15'h0001;
    assign test_bit = file_rdata_in[fld.bit_sel];
    assign bit_mask = 8'h01 << fld.bit_sel;

    // Result and file write path
    // Bit ops rewrite the whole byte from the value just read, so the
    // file read has to settle within the cycle
    always_comb begin
        result = BYTE_ZERO;
        result_valid = 1'b0;
        next_write = '0;
        next_write.addr = fld.faddr;
        unique case (op)
            // Read, mask, write back; flags untouched
            OP_BCLR: begin
                next_write.en = 1'b1;
                next_write.data = file_rdata_in & ~bit_mask;
            end
            // Same read-modify-write, bit forced high
            OP_BSET: begin
                next_write.en = 1'b1;
                next_write.data = file_rdata_in | bit_mask;
            end
            // Complement; destination bit picks file or accumulator
            OP_INV: begin
                result = ~file_rdata_in;
                result_valid = 1'b1;
                next_write.en = fld.dest_file;
                next_write.data = result;
            end
            // Wraps from 00h to FFh, zero flag follows the result
            OP_DEC: begin
                result = file_rdata_in - 8'h01;
                result_valid = 1'b1;
                next_write.en = fld.dest_file;
                next_write.data = result;
            end
            // Constant zero; the flag is set in its own process
            OP_FCLR: begin
                next_write.en = 1'b1;
                next_write.data = BYTE_ZERO;
            end
            // Branches, calls, skips and idle write nothing
            default: begin
            end
        endcase
    end

    // Skip decision for the two bit tests
    // A taken skip costs one bubble cycle; no second fetch is needed
    always_comb begin
        skip_next = 1'b0;
        if (op == OP_SKIP_LOW) begin
            skip_next = ~test_bit;
        end else if (op == OP_SKIP_HIGH) begin
            skip_next = test_bit;
        end
    end

    // Next program counter
    // The 15-bit sums wrap, so a branch past either end of memory
    // comes back in at the other end
    always_comb begin
        next_pc = pc_inc;
        unique case (op)
            // Nine-bit offset, sign-extended to the counter width
            OP_REL: next_pc = pc_inc
                + PC_W'({{(PC_W-9){fld.k9[8]}}, fld.k9});
            // Accumulator taken as unsigned
            OP_JACC: next_pc = pc_inc + PC_W'(acc);
            // Top two counter bits are kept across the call
            OP_CALL: next_pc = {pc[14:13], upper_pc_latch_in[4:3],
                fld.k11};
            // Upper bits from the latch, low byte from the accumulator
            OP_CALL_ACC: next_pc = {upper_pc_latch_in, acc};
            default: next_pc = pc_inc;
        endcase
    end

    // Program counter
    // Only place the counter is written; every word moves it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pc <= PC_RESET;
        end else begin
            pc <= next_pc;
        end
    end

    // Bubble: the word fetched after a taken jump or skip is dropped
    // Trades a cycle for the lack of any flush logic: the word already
    // fetched simply decodes as idle
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bubble <= 1'b0;
        end else begin
            bubble <= skip_next || op == OP_REL || op == OP_JACC
                || op == OP_CALL || op == OP_CALL_ACC;
        end
    end

    // Accumulator
    // Only clears and results with the destination bit low reach it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc <= BYTE_ZERO;
        end else if (op == OP_ACLR) begin
            acc <= BYTE_ZERO;
        end else if (result_valid && !fld.dest_file) begin
            acc <= result;
        end
    end

    // Zero flag; bit ops and branches leave it alone
    // Clears set it outright; computed results set it only when the
    // byte is zero, so a stale flag cannot survive a new result
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            zero_flag <= 1'b0;
        end else if (op == OP_FCLR || op == OP_ACLR) begin
            zero_flag <= 1'b1;
        end else if (result_valid) begin
            zero_flag <= (result == BYTE_ZERO);
        end
    end

    // Watchdog counter; the tick source lives outside this block, so
    // the count only ever returns to zero here and never advances
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wdt_count <= WDT_CLEAR;
        end else if (op == OP_WDT) begin
            wdt_count <= WDT_CLEAR;
        end
    end

    // Watchdog prescaler, cleared with the counter so that the first
    // period after a kick is a full one
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wdt_prescale <= WDT_CLEAR;
        end else if (op == OP_WDT) begin
            wdt_prescale <= WDT_CLEAR;
        end
    end

    // Time-out status; a time-out outside this subset would clear it,
    // and the kick only ever sets it again
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            expiry_flag <= 1'b1;
        end else if (op == OP_WDT) begin
            expiry_flag <= 1'b1;
        end
    end

    // Power-down status; only a sleep outside this subset clears it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sleep_flag <= 1'b1;
        end else if (op == OP_WDT) begin
            sleep_flag <= 1'b1;
        end
    end

    // File write request, registered so that it leaves from a flop; a
    // word reading the same register next cycle needs it forwarded
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            file_write_out <= '0;
        end else begin
            file_write_out <= next_write;
        end
    end

    // Stack push strobe, one cycle long for either call form; the
    // stack itself decides what happens when it is full
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            push_out <= 1'b0;
        end else begin
            push_out <= (op == OP_CALL || op == OP_CALL_ACC);
        end
    end

    // Return address, loaded every cycle; it only matters in the
    // cycle the push strobe is high
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            return_slot_out <= PC_RESET;
        end else begin
            return_slot_out <= pc_inc;
        end
    end

    // Kick strobe for the tick logic outside this block, which owns
    // the running count and prescaler
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            watchdog_clear_out <= 1'b0;
        end else begin
            watchdog_clear_out <= (op == OP_WDT);
        end
    end

    // Outputs straight from their flops; file address follows the word
    assign pc_out = pc;
    assign file_addr_out = fld.faddr;
    assign acc_out = acc;
    assign null_result_flag_out = zero_flag;
    assign expiry_flag_out = expiry_flag;
    assign sleep_flag_out = sleep_flag;
    assign watchdog_counter_out = wdt_count;
    assign watchdog_prescaler_out = wdt_prescale;
    assign bubble_out = bubble;

endmodule

//--- verification/subset_exec_asserts.sv
// Checker for the subset executor, watching top-level ports only.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps

module subset_exec_asserts (
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // Fetch and latch
    input wire logic [subset_exec_pkg::INSN_W-1:0] insn_in,
    input wire logic [subset_exec_pkg::PC_W-1:0] pc_out,
    input wire logic [6:0] upper_pc_latch_in,
    // Results
    input wire subset_exec_pkg::file_write_t file_write_out,
    input wire logic push_out,
    input wire logic [subset_exec_pkg::PC_W-1:0] return_slot_out,
    input wire logic [7:0] acc_out,
    input wire logic null_result_flag_out,
    input wire logic expiry_flag_out,
    input wire logic sleep_flag_out,
    input wire logic watchdog_clear_out,
    input wire logic [7:0] watchdog_counter_out,
    input wire logic bubble_out
);
    import subset_exec_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    // Taken words only; a bubble cycle executes nothing
    sequence s_call;
        !bubble_out && insn_in[13:11] == OPC_CALL;
    endsequence
    sequence s_call_acc;
        !bubble_out && insn_in == OPC_CALL_ACC;
    endsequence

    AST_CALL_PC: assert property (s_call |=> pc_out[12:0] ==
        {$past(upper_pc_latch_in[4:3]), $past(insn_in[10:0])})
        else $error("call target wrong");
    AST_CALL_ACC: assert property (s_call_acc |=> push_out &&
        pc_out == {$past(upper_pc_latch_in), $past(acc_out)})
        else $error("accumulator call target wrong");
    AST_RET_SLOT: assert property (push_out |->
        return_slot_out == $past(pc_out) + 15'h0001)
        else $error("return slot wrong");
    AST_PUSH_PULSE: assert property (push_out |-> bubble_out ##1
        !push_out && !bubble_out)
        else $error("push not a two-cycle call");
    AST_BUBBLE: assert property (bubble_out |=> !file_write_out.en &&
        pc_out == $past(pc_out) + 15'h0001)
        else $error("discarded word had an effect");
    AST_REL: assert property (!bubble_out &&
        insn_in[13:9] == OPC_REL_JUMP |=> bubble_out && pc_out ==
        $past(pc_out) + 15'h0001 +
        {{6{$past(insn_in[8])}}, $past(insn_in[8:0])})
        else $error("relative jump target wrong");
    AST_KICK: assert property (!bubble_out &&
        insn_in == OPC_WDT_KICK |=> watchdog_clear_out &&
        watchdog_counter_out == 8'h00 && expiry_flag_out && sleep_flag_out)
        else $error("watchdog kick incomplete");
    AST_BIT_FLAG: assert property (!bubble_out &&
        insn_in[13:12] == 2'b01 |=> $stable(null_result_flag_out))
        else $error("bit op touched zero flag");
    AST_ACC_ZERO: assert property (!bubble_out &&
        insn_in[13:7] == {OPC_CLEAR_GRP, 1'b0} |=> acc_out == 8'h00 &&
        null_result_flag_out)
        else $error("accumulator zeroing wrong");
endmodule

bind subset_exec subset_exec_asserts chk_u (.clock_in(clock_in),
    .resetn_in(resetn_in), .insn_in(insn_in), .pc_out(pc_out),
    .upper_pc_latch_in(upper_pc_latch_in), .file_write_out(file_write_out),
    .push_out(push_out), .return_slot_out(return_slot_out),
    .acc_out(acc_out), .null_result_flag_out(null_result_flag_out),
    .expiry_flag_out(expiry_flag_out), .sleep_flag_out(sleep_flag_out),
    .watchdog_clear_out(watchdog_clear_out),
    .watchdog_counter_out(watchdog_counter_out), .bubble_out(bubble_out));

//--- verification/subset_exec_tb.sv
// Testbench for the subset executor: one word per step, then compare.
// Assumes results show in the cycle after the edge taking the word.
`timescale 1ns/1ps

module subset_exec_tb;
    import subset_exec_pkg::*;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [13:0] insn_in = 14'h0000;
    logic [7:0] file_rdata_in = 8'h00;
    logic [6:0] upper_pc_latch_in = 7'h18;
    logic [14:0] pc_out;
    logic [14:0] return_slot_out;
    logic [14:0] epc;
    logic [6:0] file_addr_out;
    file_write_t file_write_out;
    logic [7:0] acc_out;
    logic [7:0] watchdog_counter_out;
    logic [7:0] watchdog_prescaler_out;
    logic push_out, null_result_flag_out, expiry_flag_out, sleep_flag_out;
    logic watchdog_clear_out, bubble_out;
    int mismatches = 0;
    int samples_checked = 0;

    // Free-running instruction clock
    always #50 clock_in = ~clock_in;

    subset_exec dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
        .insn_in(insn_in), .pc_out(pc_out), .file_addr_out(file_addr_out),
        .file_rdata_in(file_rdata_in), .file_write_out(file_write_out),
        .upper_pc_latch_in(upper_pc_latch_in), .push_out(push_out),
        .return_slot_out(return_slot_out), .acc_out(acc_out),
        .null_result_flag_out(null_result_flag_out),
        .expiry_flag_out(expiry_flag_out), .sleep_flag_out(sleep_flag_out),
        .watchdog_clear_out(watchdog_clear_out),
        .watchdog_counter_out(watchdog_counter_out),
        .watchdog_prescaler_out(watchdog_prescaler_out),
        .bubble_out(bubble_out));

    task finish_test;
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask

    // Word and file data launched 1 ns after an edge, taken at the next
    task step(input logic [13:0] w, input logic [7:0] rd,
        input logic [14:0] np);
        insn_in <= w;
        file_rdata_in <= rd;
        @(posedge clock_in);
        #1;
        epc = np;
        chk({1'b0, pc_out}, {1'b0, epc});
    endtask

    // Zero flag, accumulator and bubble packed in one compare
    task state(input logic [7:0] a, input logic z);
        chk({acc_out, 6'h00, null_result_flag_out, bubble_out}, {a, 6'h00, z,
            1'b0});
    endtask

    // Two-cycle word: the following word must be dropped
    task two(input logic [13:0] w, input logic [7:0] rd,
        input logic [14:0] np, input logic p);
        logic [14:0] ret;
        ret = epc + 15'h0001;
        step(w, rd, np);
        chk({14'h0000, push_out, bubble_out}, {14'h0000, p, 1'b1});
        if (p) begin
            chk({1'b0, return_slot_out}, {1'b0, ret});
        end
        step(14'h1405, 8'h00, epc + 15'h0001);
        chk({15'h0000, file_write_out.en | bubble_out}, 16'h0000);
    endtask

    initial begin
        @(posedge clock_in);
        #1;
        chk({acc_out, 3'h0, null_result_flag_out, expiry_flag_out,
            sleep_flag_out, push_out, bubble_out}, 16'h000C);
        @(posedge clock_in);
        resetn_in <= 1'b1;
        #1;
        epc = PC_RESET;
        step(14'h0300, 8'h10, epc + 15'h0001);
        state(8'h0F, 1'b0);
        step(14'h0100, 8'h10, epc + 15'h0001);
        state(8'h00, 1'b1);
        step(14'h13FF, 8'hFF, epc + 15'h0001);
        chk(file_write_out, 16'hFF7F);
        chk({9'h000, file_addr_out}, 16'h007F);
        step(14'h1405, 8'h00, epc + 15'h0001);
        chk(file_write_out, 16'h8501);
        state(8'h00, 1'b1);
        step(14'h0991, 8'h0F, epc + 15'h0001);
        chk(file_write_out, 16'h91F0);
        state(8'h00, 1'b0);
        step(14'h0903, 8'hFF, epc + 15'h0001);
        state(8'h00, 1'b1);
        step(14'h03C4, 8'h00, epc + 15'h0001);
        chk(file_write_out, 16'hC4FF);
        state(8'h00, 1'b0);
        step(14'h01A2, 8'h55, epc + 15'h0001);
        chk(file_write_out, 16'hA200);
        state(8'h00, 1'b1);
        two(14'h1909, 8'hFB, epc + 15'h0001, 1'b0);
        step(14'h1909, 8'h04, epc + 15'h0001);
        state(8'h00, 1'b1);
        two(14'h1D09, 8'h04, epc + 15'h0001, 1'b0);
        step(14'h1D09, 8'hFB, epc + 15'h0001);
        state(8'h00, 1'b1);
        two(14'h3300, 8'h00, epc + 15'h7F01, 1'b0);
        two(14'h32FF, 8'h00, epc + 15'h0100, 1'b0);
        step(14'h0300, 8'h10, epc + 15'h0001);
        two(14'h000B, 8'h00, epc + 15'h0010, 1'b0);
        two(14'h27FF, 8'h00, {epc[14:13], 2'b11, 11'h7FF}, 1'b1);
        upper_pc_latch_in <= 7'h55;
        two(14'h000A, 8'h00, 15'h550F, 1'b1);
        state(8'h0F, 1'b0);
        step(14'h0064, 8'h00, epc + 15'h0001);
        chk({watchdog_counter_out, watchdog_prescaler_out}, 16'h0000);
        chk({13'h0000, watchdog_clear_out, expiry_flag_out,
            sleep_flag_out}, 16'h0007);
        finish_test();
    end
endmodule
